// ---- src/aozq_core.sv ----
// Function
// - Async termination when DLL frozen in power-down
// - Async path ignores additive latency
// - Turn-on between 1 and 9 ns
// - Turn-off between 1 and 9 ns
// - ODT receiver stays active in power-down
// - Entry window WL-1 before CKE low
// - Refresh in progress extends entry window tRFC
// - Window allows either sync or async timing
// - Exit window max ODTL before, tXPDLL after
// - Overlapping entry/exit windows merge into one
// - Overlapping exit/entry windows merge into one
// - First long calibration tZQinit, later tZQoper
// - Short calibration completes within tZQCS
// - Cut calibration current once values applied
// - No calibration after self-refresh unless commanded
// - Calibration decode, A10 selects long/short
`include "aozq_regs.svh"

module aozq_core
  import aozq_pkg::*;
#(
  parameter int WL = `AOZQ_WL_DEF,
  parameter int AL = 0,
  parameter int ODTL_ON = `AOZQ_ODTL_DEF,
  parameter int ODTL_OFF = `AOZQ_ODTL_DEF,
  parameter int TRFC_CYC = `AOZQ_TRFC_CYC,
  parameter int TXPDLL_CYC = `AOZQ_TXPDLL_CYC,
  parameter int ZQINIT_CYC = `AOZQ_ZQINIT_CYC,
  parameter int ZQOPER_CYC = `AOZQ_ZQOPER_CYC,
  parameter int ZQCS_CYC = `AOZQ_ZQCS_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cke,
  input wire logic odt,
  input wire aozq_cmd_type cmd,
  input wire logic [15:0] addr,
  input wire logic mr0_write,
  input wire logic refresh_cmd,
  output aozq_odt_type odt_state,
  output logic cal_busy,
  output logic cal_done,
  output logic zq_current_on
);

  localparam int CW = 16;
  localparam int DLY = 64;
  localparam int ENTRY_LEAD = (WL > 1) ? WL - 1 : 1;
  localparam int EXIT_LEAD = (ODTL_ON > ODTL_OFF) ? ODTL_ON : ODTL_OFF;
  localparam int SYNC_DLY = AL + ODTL_ON + 1;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  function automatic logic is_zq(input aozq_cmd_type c, input logic ck_prev, input logic ck_cur);
    is_zq = ck_prev && ck_cur && !c.cs_n && c.ras_n && c.cas_n && !c.we_n;
  endfunction

  logic cke_prev;
  logic dll_frozen;
  aozq_pd_type pd_state;
  logic zq_cmd;
  logic pd_enter;
  logic pd_exit;

  assign zq_cmd = is_zq(cmd, cke_prev, cke) && (pd_state == AOZQ_PD_ACTIVE);
  assign pd_enter = cke_prev && !cke;
  assign pd_exit = !cke_prev && cke;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cke_prev <= 1'b0;
    end else if (clk_en) begin
      cke_prev <= cke;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dll_frozen <= 1'b1;
    end else if (clk_en && mr0_write) begin
      dll_frozen <= !addr[`AOZQ_MR0_PPD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_state <= AOZQ_PD_ACTIVE;
    end else if (clk_en) begin
      case (pd_state)
        AOZQ_PD_ACTIVE: begin
          if (pd_enter) begin
            pd_state <= AOZQ_PD_DOWN;
          end
        end
        AOZQ_PD_DOWN: begin
          if (pd_exit) begin
            pd_state <= AOZQ_PD_ACTIVE;
          end
        end
        default: begin
          pd_state <= AOZQ_PD_ACTIVE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Transition windows
  // ****************************************************************
  // The window opens before the CKE edge, so the device cannot know it
  // early; instead the ODT history over the lead is treated as uncertain
  // by holding the flag on for that lead after the edge as well.
  logic [CW-1:0] refresh_left;
  logic [CW-1:0] win_left;
  logic [CW-1:0] next_win_left;
  logic window;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refresh_left <= '0;
    end else if (clk_en) begin
      if (refresh_cmd) begin
        refresh_left <= CW'(TRFC_CYC);
      end else if (refresh_left != '0) begin
        refresh_left <= refresh_left - 1'b1;
      end
    end
  end

  always_comb begin
    next_win_left = (win_left != '0) ? win_left - 1'b1 : '0;
    if (dll_frozen && pd_enter) begin
      // entry window held for the lead after CKE low
      next_win_left = CW'(ENTRY_LEAD);
      if (refresh_left > next_win_left) begin
        next_win_left = refresh_left;
      end
    end else if (dll_frozen && pd_exit) begin
      // exit window spans lead plus tXPDLL
      next_win_left = CW'(EXIT_LEAD + TXPDLL_CYC);
    end
    // later window keeps earlier one open
    if (win_left > next_win_left) begin
      next_win_left = win_left - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      win_left <= '0;
    end else if (clk_en) begin
      win_left <= next_win_left;
    end
  end

  assign window = (win_left != '0);

  // ****************************************************************
  // Termination control
  // ****************************************************************
  // ODT sampled every cycle, even in power-down
  logic [DLY-1:0] odt_hist;
  logic async_mode;
  logic rtt_on;
  logic rtt_target;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      odt_hist <= '0;
    end else if (clk_en) begin
      odt_hist <= {odt_hist[DLY-2:0], odt};
    end
  end

  assign async_mode = dll_frozen && (pd_state == AOZQ_PD_DOWN);

  always_comb begin
    if (async_mode || window) begin
      // window uses async timing inside legal range
      // Taken straight from the pin so the change lands on the sampling edge;
      // a second flop here would push it a whole 40 ns past that edge
      rtt_target = odt;
    end else begin
      rtt_target = odt_hist[SYNC_DLY - 1];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rtt_on <= 1'b0;
    end else if (clk_en) begin
      rtt_on <= rtt_target;
    end
  end

  assign odt_state.rtt_on = rtt_on;
  assign odt_state.async_mode = async_mode;
  assign odt_state.uncertain = window;

  // ****************************************************************
  // Calibration engine
  // ****************************************************************
  aozq_cal_type cal_state;
  logic [CW-1:0] cal_left;
  logic first_long_done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_state <= AOZQ_CAL_IDLE;
      cal_left <= '0;
      first_long_done <= 1'b0;
    end else if (clk_en) begin
      case (cal_state)
        AOZQ_CAL_IDLE: begin
          // only an explicit command starts calibration
          if (zq_cmd) begin
            cal_state <= AOZQ_CAL_RUN;
            if (addr[`AOZQ_ZQ_LONG_BIT]) begin
              cal_left <= first_long_done ? CW'(ZQOPER_CYC - 1) : CW'(ZQINIT_CYC - 1);
              first_long_done <= 1'b1;
            end else begin
              cal_left <= CW'(ZQCS_CYC - 1);
            end
          end
        end
        AOZQ_CAL_RUN: begin
          if (cal_left <= CW'(1)) begin
            cal_state <= AOZQ_CAL_APPLY;
          end else begin
            cal_left <= cal_left - 1'b1;
          end
        end
        AOZQ_CAL_APPLY: begin
          cal_state <= AOZQ_CAL_IDLE;
          cal_left <= '0;
        end
        default: begin
          cal_state <= AOZQ_CAL_IDLE;
        end
      endcase
    end
  end

  assign zq_current_on = (cal_state == AOZQ_CAL_RUN);
  assign cal_busy = (cal_state != AOZQ_CAL_IDLE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_done <= 1'b0;
    end else if (clk_en) begin
      cal_done <= (cal_state == AOZQ_CAL_APPLY);
    end
  end

endmodule // aozq_core

// ---- src/aozq_regs.svh ----
`ifndef AOZQ_REGS_SVH
`define AOZQ_REGS_SVH
// Clock period in picoseconds (25 MHz)
`define AOZQ_CLK_PS 40000
// Asynchronous termination delays, ns
`define AOZQ_TAONPD_MIN_NS 1
`define AOZQ_TAONPD_MAX_NS 9
`define AOZQ_TAOFPD_MIN_NS 1
`define AOZQ_TAOFPD_MAX_NS 9
// Least time rounds up, longest rounds down, never below one cycle
`define AOZQ_CYC_UP(ns) ((((ns) * 1000 + `AOZQ_CLK_PS - 1) / `AOZQ_CLK_PS) < 1 ? 1 : \
  (((ns) * 1000 + `AOZQ_CLK_PS - 1) / `AOZQ_CLK_PS))
`define AOZQ_CYC_DN(ns) ((((ns) * 1000) / `AOZQ_CLK_PS) < 1 ? 1 : (((ns) * 1000) / `AOZQ_CLK_PS))
`define AOZQ_AON_CYC `AOZQ_CYC_UP(`AOZQ_TAONPD_MIN_NS)
`define AOZQ_AOF_CYC `AOZQ_CYC_UP(`AOZQ_TAOFPD_MIN_NS)
// Mode register 0 bit that keeps the DLL running in power-down
`define AOZQ_MR0_PPD_BIT 12
// Address bit choosing long or short calibration
`define AOZQ_ZQ_LONG_BIT 10
// Default calibration, refresh, DLL-exit and latency values in cycles
`define AOZQ_ZQINIT_CYC 512
`define AOZQ_ZQOPER_CYC 256
`define AOZQ_ZQCS_CYC 64
`define AOZQ_TRFC_CYC 44
`define AOZQ_TXPDLL_CYC 10
`define AOZQ_WL_DEF 5
`define AOZQ_ODTL_DEF 3
`endif

// ---- src/aozq_pkg.sv ----
package aozq_pkg;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } aozq_cmd_type;

  typedef enum logic [1:0] {
    AOZQ_PD_ACTIVE,
    AOZQ_PD_DOWN
  } aozq_pd_type;

  typedef enum logic [1:0] {
    AOZQ_CAL_IDLE,
    AOZQ_CAL_RUN,
    AOZQ_CAL_APPLY
  } aozq_cal_type;

  typedef struct packed {
    logic rtt_on;
    logic async_mode;
    logic uncertain;
  } aozq_odt_type;
endpackage

// ---- bench/aozq_ctrl_model.sv ----
// ****
// Controller side
// ****
module aozq_ctrl_model
  import aozq_pkg::*;
(
  input wire logic clk,
  output logic cke,
  output logic odt,
  output aozq_cmd_type cmd,
  output logic [15:0] addr,
  output logic mr0_write,
  output logic refresh_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cke = 1'b1;
    odt = 1'b0;
    cmd = 4'hF;
    addr = 16'h0000;
    mr0_write = 1'b0;
    refresh_cmd = 1'b0;
  end
  // idle banks, one device, ODT low
  task automatic send(input aozq_cmd_type c, input logic [15:0] a, input logic mr,
    input logic rf, input int reps);
    @(negedge clk);
    cke = 1'b1;
    odt = 1'b0;
    cmd = c;
    addr = a;
    mr0_write = mr;
    refresh_cmd = rf;
    repeat (reps) @(negedge clk);
    cmd = 4'hF;
    // Deselected address lines do not keep their value
    addr = ~a;
    mr0_write = 1'b0;
    refresh_cmd = 1'b0;
  endtask
  task automatic pins(input logic k, input logic o);
    @(negedge clk);
    cke = k;
    odt = o;
  endtask
endmodule // aozq_ctrl_model

// ---- bench/aozq_core_assertions.sv ----
// ****
// Checks
// ****
module aozq_core_assertions
  import aozq_pkg::*;
#(
  parameter int ZQINIT_CYC = 8,
  parameter int ZQOPER_CYC = 6,
  parameter int ZQCS_CYC = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic odt,
  input wire aozq_cmd_type cmd,
  input wire logic [15:0] addr,
  input wire logic mr0_write,
  input wire aozq_odt_type odt_state,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire logic zq_current_on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cke_q, first, frozen, taken;
  logic [7:0] cnt, need;
  assign taken = cke && cke_q && cmd == 4'h6 && !cal_busy;
  always_ff @(posedge clk) begin
    cke_q <= cke;
    cnt <= taken ? 8'h01 : cnt + 8'h01;
    if (taken)
      need <= 8'(!addr[10] ? ZQCS_CYC : first ? ZQINIT_CYC : ZQOPER_CYC);
    if (sys_rst) begin
      first <= 1'b1;
      frozen <= 1'b1;
    end else begin
      if (mr0_write)
        frozen <= !addr[12];
      if (taken && addr[10])
        first <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_zq_start: assert property (taken |=> cal_busy && zq_current_on)
    else $error("no start");
  a_no_start: assert property (!cal_busy && !taken |=> !cal_busy)
    else $error("false start");
  a_zq_length: assert property (cal_done |-> cnt == need + 8'h01)
    else $error("bad length");
  a_apply_step: assert property (cal_busy && !zq_current_on |=> cal_done && !cal_busy)
    else $error("bad apply");
  a_async_sel: assert property (1'b1 |=> odt_state.async_mode == (!$past(cke) && frozen))
    else $error("bad mode");
  a_async_path: assert property (odt_state.async_mode || odt_state.uncertain
    |=> odt_state.rtt_on == $past(odt))
    else $error("bad async");
  a_sync_path: assert property ((!odt_state.async_mode && !odt_state.uncertain)[*5]
    |-> odt_state.rtt_on == $past(odt, 5))
    else $error("bad sync");
  // Window lengths sized for the bench's short latencies
  a_entry_win: assert property (cke_q && !cke && frozen |=> odt_state.uncertain[*4])
    else $error("short entry");
  a_exit_win: assert property (!cke_q && cke && frozen |=> odt_state.uncertain[*6])
    else $error("short exit");
endmodule // aozq_core_assertions

bind aozq_core aozq_core_assertions #(.ZQINIT_CYC(ZQINIT_CYC), .ZQOPER_CYC(ZQOPER_CYC),
  .ZQCS_CYC(ZQCS_CYC)) u_aozq_core_assertions (.clk(clk), .sys_rst(sys_rst), .cke(cke),
  .odt(odt), .cmd(cmd), .addr(addr), .mr0_write(mr0_write), .odt_state(odt_state),
  .cal_busy(cal_busy), .cal_done(cal_done), .zq_current_on(zq_current_on));

// ---- bench/async_odt_and_zq_calibration_bench.sv ----
// ****
// Bench top
// ****
module async_odt_and_zq_calibration_bench
  import aozq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic cke, odt, mr0_write, refresh_cmd, cal_busy, cal_done, zq_current_on;
  aozq_cmd_type cmd;
  logic [15:0] addr;
  aozq_odt_type odt_state;
  int err_count = 0;
  int compares = 0;
  int n;
  always #20 clk = ~clk;
  aozq_core #(.ZQINIT_CYC(8), .ZQOPER_CYC(6), .ZQCS_CYC(4), .TRFC_CYC(10), .TXPDLL_CYC(3))
    u_aozq_core (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cke(cke), .odt(odt),
    .cmd(cmd), .addr(addr), .mr0_write(mr0_write), .refresh_cmd(refresh_cmd),
    .odt_state(odt_state), .cal_busy(cal_busy), .cal_done(cal_done),
    .zq_current_on(zq_current_on));
  aozq_ctrl_model u_aozq_ctrl_model (.clk(clk), .cke(cke), .odt(odt), .cmd(cmd),
    .addr(addr), .mr0_write(mr0_write), .refresh_cmd(refresh_cmd));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t saw %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic wait_for(input int s, input logic v);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((s == 0 ? cal_done : s == 1 ? odt_state.rtt_on : odt_state.uncertain) !== v
      && n < 40);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_cal;
    for (int i = 0; i < 3; i++) begin
      u_aozq_ctrl_model.send(4'h6, i < 2 ? 16'h0400 : 16'h0000, 1'b0, 1'b0, 1);
      wait_for(0, 1'b1);
      check(8'(n), i == 0 ? 8'h08 : i == 1 ? 8'h06 : 8'h04);
      check(zq_current_on, 1'b0);
    end
    $display("t_cal end");
  endtask
  task automatic t_refuse;
    // Second edge of a held command lands while busy
    u_aozq_ctrl_model.send(4'h6, 16'h0000, 1'b0, 1'b0, 2);
    wait_for(0, 1'b1);
    check(8'(n), 8'h03);
    for (int i = 0; i < 2; i++) begin
      u_aozq_ctrl_model.send(i == 0 ? 4'h7 : 4'h2, 16'h0400, 1'b0, 1'b0, 1);
      check(cal_busy, 1'b0);
    end
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    repeat (3) @(negedge clk);
    u_aozq_ctrl_model.send(4'h6, 16'h0400, 1'b0, 1'b0, 1);
    check(cal_busy, 1'b0);
    repeat (10) @(negedge clk);
    $display("t_refuse end");
  endtask
  task automatic t_odt;
    u_aozq_ctrl_model.pins(1'b1, 1'b1);
    wait_for(1, 1'b1);
    check(8'(n), 8'h05);
    u_aozq_ctrl_model.pins(1'b1, 1'b0);
    wait_for(1, 1'b0);
    check(8'(n), 8'h05);
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    repeat (8) @(negedge clk);
    check(odt_state.async_mode, 1'b1);
    u_aozq_ctrl_model.pins(1'b0, 1'b1);
    wait_for(1, 1'b1);
    check(8'(n), 8'h01);
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    wait_for(1, 1'b0);
    check(8'(n), 8'h01);
    u_aozq_ctrl_model.pins(1'b1, 1'b0);
    repeat (10) @(negedge clk);
    $display("t_odt end");
  endtask
  task automatic t_win;
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    wait_for(2, 1'b0);
    check(8'(n), 8'h05);
    u_aozq_ctrl_model.pins(1'b1, 1'b0);
    wait_for(2, 1'b0);
    check(8'(n), 8'h07);
    u_aozq_ctrl_model.send(4'h1, 16'h0000, 1'b0, 1'b1, 1);
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    wait_for(2, 1'b0);
    check(n >= 9 && n <= 11, 1'b1);
    u_aozq_ctrl_model.pins(1'b1, 1'b0);
    wait_for(2, 1'b0);
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    u_aozq_ctrl_model.pins(1'b1, 1'b0);
    wait_for(2, 1'b0);
    check(8'(n), 8'h07);
    $display("t_win end");
  endtask
  task automatic t_dll;
    u_aozq_ctrl_model.send(4'h0, 16'h1000, 1'b1, 1'b0, 1);
    u_aozq_ctrl_model.pins(1'b0, 1'b0);
    repeat (8) @(negedge clk);
    check(odt_state.async_mode, 1'b0);
    u_aozq_ctrl_model.send(4'h0, 16'h0000, 1'b1, 1'b0, 1);
    repeat (8) @(negedge clk);
    $display("t_dll end");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check({odt_state, cal_busy, cal_done, zq_current_on}, 8'h00);
    t_cal();
    t_refuse();
    t_odt();
    t_win();
    t_dll();
    complete_run();
  end
  // Whole run is about 150 cycles
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule // async_odt_and_zq_calibration_bench
